/* rtl/opm_ctrl.sv */
// oscillator select and stop/wait/halt sequencer with apb registers
// assumes all inputs synchronous to clk; peripherals act on the clear pulses
`timescale 1ns/1ps
`include "opm_consts.svh"
module opm_ctrl
    import opm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        stop_req,
    input  wire logic        wait_req,
    input  wire logic        ext_irq_pin_n,
    input  wire logic [3:0]  port_a_wake_pins,
    input  wire logic        reset_pin_n,
    input  wire logic        watchdog_timeout,
    input  wire opm_wake_t   periph_irq,
    input  wire logic        port_int_option,
    input  wire logic        halt_option,
    input  wire logic        long_delay_option,
    output opm_osc_t         osc_ctrl,
    output logic             osc_run,
    output logic             periph_clk_en,
    output logic             watchdog_clk_en,
    output logic             bus_clk_en,
    output logic             cpu_reset,
    output logic             irq_mask_clear,
    output logic             core_timer_clear,
    output logic             prog_timer_clear,
    output logic             vector_valid,
    output logic      [15:0] vector_addr
);
    opm_state_t  state_r;            // sequencer state
    logic [1:0]  sel_r;              // oscillator select bits
    logic        ena_r;              // ext_int_enable
    logic        flag_r;             // ext_int_flag
    logic        irq_q_r;            // previous pin level for edge detect
    logic [3:0]  pa_q_r;             // previous port levels
    logic [11:0] cnt_r;              // delay counter
    logic [11:0] delay_len;          // chosen full delay
    logic        ext_edge;           // falling pin or rising port edge
    logic        wr;                 // apb write strobe
    logic        clr_wr;             // software clears the flag
    logic        halt_mode_r;        // current low-power came from halt

    assign wr        = psel && penable && pwrite;
    assign delay_len = long_delay_option ? 12'(`OPM_LONG_CYC) : 12'(`OPM_SHORT_CYC);
    // port edges count only when the option enables them
    assign ext_edge  = (irq_q_r && !ext_irq_pin_n)
                     || (port_int_option && |(port_a_wake_pins & ~pa_q_r));
    assign clr_wr    = wr && (paddr == `OPM_CTRL_OFF) && pwdata[`OPM_CLR_BIT];

    // edge detect registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_q_r <= 1'b1;
            pa_q_r  <= 4'h0;
        end
        else
        begin
            irq_q_r <= ext_irq_pin_n;
            pa_q_r  <= port_a_wake_pins;
        end
    end

    // select bits: reset picks internal, stop leaves them alone
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sel_r <= 2'(`OPM_CTRL_RST & 8'h03);
        else if (wr && paddr == `OPM_CTRL_OFF)
            sel_r <= pwdata[1:0]; // software owns settle time
    end

    // flag: set wins over clear so no pending request is lost
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            flag_r <= 1'b0;
        else if (ext_edge)
            flag_r <= 1'b1;
        else if (clr_wr)
            flag_r <= 1'b0;
    end

    // enable bit: forced on entering stop, wait or halt
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ena_r <= 1'b1;
        else if (state_r == OPM_RUN && bus_clk_en && (stop_req || wait_req))
            ena_r <= 1'b1;
        else if (wr && paddr == `OPM_CTRL_OFF)
            ena_r <= pwdata[`OPM_ENA_BIT];
    end

    // sequencer; reset pin in low power or watchdog in wait/halt ends in reset vector
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r     <= OPM_POR;
            cnt_r       <= 12'(`OPM_SHORT_CYC);
            halt_mode_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                OPM_POR:
                begin
                    if (cnt_r > delay_len)
                        cnt_r <= delay_len;
                    else if (cnt_r > 12'h001)
                        cnt_r <= cnt_r - 12'h001;
                    else if (reset_pin_n)
                        state_r <= OPM_RUN;
                end
                OPM_RUN:
                begin
                    // requests count only while the bus clock runs, like the entry pulses
                    if (bus_clk_en && stop_req && !halt_option)
                        state_r <= OPM_STOP;
                    else if (bus_clk_en && (stop_req || wait_req))
                    begin
                        state_r     <= OPM_WAIT;
                        halt_mode_r <= stop_req;
                    end
                end
                OPM_STOP:
                begin
                    if (!reset_pin_n)
                    begin
                        state_r <= OPM_POR;
                        cnt_r   <= delay_len;
                    end
                    else if (ext_edge && ena_r)
                    begin
                        state_r <= OPM_RECOV;
                        cnt_r   <= delay_len;
                    end
                end
                OPM_WAIT:
                begin
                    if (!reset_pin_n || watchdog_timeout)
                    begin
                        state_r <= OPM_POR;
                        cnt_r   <= delay_len;
                    end
                    else if ((ext_edge && ena_r) || |periph_irq)
                    begin
                        // halt wakes into a full recovery count; plain wait goes straight to run
                        state_r <= halt_mode_r ? OPM_RECOV : OPM_RUN;
                        cnt_r   <= delay_len;
                    end
                end
                OPM_RECOV:
                begin
                    if (!reset_pin_n)
                        state_r <= OPM_POR;
                    else if (cnt_r > 12'h001)
                        cnt_r <= cnt_r - 12'h001;
                    else
                        state_r <= OPM_RUN;
                end
                default: state_r <= OPM_POR;
            endcase
        end
    end

    // registered outputs that follow the state and the select bits
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            osc_ctrl         <= '{int_osc_en: 1'b1, ext_osc_en: 1'b0, ext_src: 1'b0};
            osc_run          <= 1'b1;
            periph_clk_en    <= 1'b0;
            watchdog_clk_en  <= 1'b0;
            bus_clk_en       <= 1'b0;
            cpu_reset        <= 1'b1;
            irq_mask_clear   <= 1'b0;
            core_timer_clear <= 1'b0;
            prog_timer_clear <= 1'b0;
        end
        else
        begin
            // 00/10 internal, 01 external, 11 both with internal source
            osc_ctrl.int_osc_en <= !(sel_r == 2'b01);
            osc_ctrl.ext_osc_en <= sel_r[0];
            osc_ctrl.ext_src    <= (sel_r == 2'b01);
            osc_run          <= (state_r != OPM_STOP);
            periph_clk_en    <= (state_r != OPM_STOP) && (state_r != OPM_POR);
            watchdog_clk_en  <= (state_r != OPM_STOP) && (state_r != OPM_POR);
            bus_clk_en       <= (state_r == OPM_RUN) && !((stop_req || wait_req) && bus_clk_en);
            cpu_reset        <= (state_r == OPM_POR);
            irq_mask_clear   <= (state_r == OPM_RUN) && bus_clk_en && (stop_req || wait_req);
            core_timer_clear <= (state_r == OPM_RUN) && bus_clk_en && stop_req && !halt_option;
            prog_timer_clear <= (state_r == OPM_RUN) && bus_clk_en && stop_req && !halt_option;
        end
    end

    // vector choice pulse on wake, by source priority
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            vector_valid <= 1'b0;
            vector_addr  <= `OPM_VEC_RESET;
        end
        else
        begin
            vector_valid <= 1'b0;
            if ((state_r == OPM_STOP || state_r == OPM_WAIT) && reset_pin_n)
            begin
                if (state_r == OPM_WAIT && watchdog_timeout)
                begin
                    vector_valid <= 1'b1;
                    vector_addr  <= `OPM_VEC_RESET;
                end
                else if (ext_edge && ena_r)
                begin
                    vector_valid <= 1'b1;
                    vector_addr  <= `OPM_VEC_EXT;
                end
                else if (state_r == OPM_WAIT && periph_irq.core)
                begin
                    vector_valid <= 1'b1;
                    vector_addr  <= `OPM_VEC_CORE;
                end
                else if (state_r == OPM_WAIT && periph_irq.ptmr)
                begin
                    vector_valid <= 1'b1;
                    vector_addr  <= `OPM_VEC_PTMR;
                end
                else if (state_r == OPM_WAIT && periph_irq.ser)
                begin
                    vector_valid <= 1'b1;
                    vector_addr  <= `OPM_VEC_SER;
                end
                else if (state_r == OPM_WAIT && periph_irq.ana)
                begin
                    vector_valid <= 1'b1;
                    vector_addr  <= `OPM_VEC_ANA;
                end
            end
            else if ((state_r != OPM_POR) && !reset_pin_n)
            begin
                vector_valid <= 1'b1;
                vector_addr  <= `OPM_VEC_RESET;
            end
        end
    end

    // apb slave: zero wait state, unmapped reads zero with error
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                if (paddr == `OPM_CTRL_OFF)
                    prdata <= {24'h000000, ena_r, 3'b000, flag_r, 1'b0, sel_r};
                else if (paddr == `OPM_STAT_OFF)
                    prdata <= {27'h0000000, state_r};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // set beats clear when both land in one cycle
    a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        ext_edge |=> flag_r) else $error("flag lost an edge");

    // a clear with no edge in the same cycle empties the flag
    a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        clr_wr && !ext_edge |=> !flag_r) else $error("flag not cleared");

    // code 01 hands the device clock to the external oscillator
    a_sel_decode: assert property (@(posedge clk) disable iff (!rst_n)
        sel_r == 2'b01 |=> osc_ctrl.ext_src && !osc_ctrl.int_osc_en) else $error("bad decode");

    // code 11 warms the external oscillator but keeps the internal source
    a_both_osc: assert property (@(posedge clk) disable iff (!rst_n)
        sel_r == 2'b11 |=> osc_ctrl.ext_osc_en && !osc_ctrl.ext_src) else $error("11 decode");

    // stop freezes the oscillators and with them the watchdog
    a_stop_osc_off: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_STOP |=> !osc_run && !watchdog_clk_en) else $error("osc on in stop");

    // wait and halt keep the watchdog clocked while the bus is gated
    a_halt_wdog_on: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_WAIT |=> watchdog_clk_en && !bus_clk_en) else $error("wait clocks");

    // short recovery lasts at least eight cycles
    a_recov_len: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_r == OPM_RECOV) && !long_delay_option && reset_pin_n
        |-> (state_r == OPM_RECOV)[*8]) else $error("recovery too short");

    // stop entry is announced by all three clear pulses
    a_stop_clears: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_r == OPM_STOP) |-> core_timer_clear && prog_timer_clear && irq_mask_clear)
        else $error("stop clear missing");

    // watchdog timeout in wait restarts through the power-up delay
    a_wdog_reset: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_WAIT && watchdog_timeout |=> state_r == OPM_POR ##1 cpu_reset)
        else $error("watchdog no reset");

    // a stop or wait request raises the enable and unmasks the core
    a_entry_unmask: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_RUN && bus_clk_en && (stop_req || wait_req)
        |=> ena_r && irq_mask_clear) else $error("entry left mask or enable");

    // plain stop enters stop mode and clears both timers
    a_stop_entry: assert property (@(posedge clk) disable iff (!rst_n)
        !halt_option && state_r == OPM_RUN && bus_clk_en && stop_req
        |=> state_r == OPM_STOP && core_timer_clear && prog_timer_clear) else $error("stop entry");

    // with the halt option set stop becomes halt, so the watchdog stays clocked
    a_halt_entry: assert property (@(posedge clk) disable iff (!rst_n)
        halt_option && state_r == OPM_RUN && bus_clk_en && stop_req
        |=> state_r == OPM_WAIT && halt_mode_r) else $error("halt entry");

    // select bits survive stop unless software writes them
    a_stop_keeps_sel: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_STOP && !(wr && paddr == `OPM_CTRL_OFF)
        |=> $stable(sel_r)) else $error("select changed in stop");

    // plain wait resumes with no count once the bus clock returns
    a_wait_no_delay: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_WAIT && !halt_mode_r && reset_pin_n && !watchdog_timeout && |periph_irq
        |=> state_r == OPM_RUN ##1 bus_clk_en) else $error("wait exit delayed");

    // halt wakes into the recovery count
    a_halt_recovers: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_WAIT && halt_mode_r && reset_pin_n && !watchdog_timeout && ext_edge && ena_r
        |=> state_r == OPM_RECOV) else $error("halt skipped recovery");

    // reset pin in stop goes back through power-up
    a_stop_pin_reset: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_STOP && !reset_pin_n
        |=> state_r == OPM_POR) else $error("stop ignored reset pin");

    // an enabled pin edge in stop or wait points at the external vector
    a_ext_vector: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == OPM_STOP || state_r == OPM_WAIT) && reset_pin_n && ext_edge && ena_r
        && !(state_r == OPM_WAIT && watchdog_timeout)
        |=> vector_valid && vector_addr == `OPM_VEC_EXT) else $error("wrong external vector");

    // core timer request wakes wait with its own vector
    a_core_vector: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_WAIT && reset_pin_n && !watchdog_timeout && !(ext_edge && ena_r) && periph_irq.core
        |=> vector_valid && vector_addr == `OPM_VEC_CORE) else $error("wrong core timer vector");

    // programmable timer request ranks below the core timer
    a_ptmr_vector: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_WAIT && reset_pin_n && !watchdog_timeout && !(ext_edge && ena_r)
        && !periph_irq.core && periph_irq.ptmr
        |=> vector_valid && vector_addr == `OPM_VEC_PTMR) else $error("wrong timer vector");

    // power-up and low-power resets hold the core in reset
    a_por_holds: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_POR
        |=> cpu_reset) else $error("core left reset early");

    // recovery keeps the bus clock gated until the count ends
    a_recov_gated: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == OPM_RECOV
        |=> !bus_clk_en) else $error("bus clock during recovery");
endmodule // opm_ctrl

/* common/opm_consts.svh */
// constants for the oscillator select and low-power mode controller
// assumes a single 100 MHz clock and a 32-bit apb register port
`ifndef OPM_CONSTS_SVH
`define OPM_CONSTS_SVH
`define OPM_CTRL_OFF      12'h000
`define OPM_STAT_OFF      12'h004
`define OPM_SEL_LO_BIT    0
`define OPM_SEL_HI_BIT    1
`define OPM_FLAG_BIT      3
`define OPM_CLR_BIT       5
`define OPM_ENA_BIT       7
`define OPM_CTRL_RST      8'h82
`define OPM_CLK_MHZ       100
`define OPM_BUS_NS        10
`define OPM_BUS_DIV       (`OPM_BUS_NS * `OPM_CLK_MHZ / 1000)
`define OPM_SHORT_CYC     16
`define OPM_LONG_CYC      4064
`define OPM_VEC_RESET     16'h1FFE
`define OPM_VEC_EXT       16'h1FFA
`define OPM_VEC_CORE      16'h1FF8
`define OPM_VEC_PTMR      16'h1FF6
`define OPM_VEC_SER       16'h1FF4
`define OPM_VEC_ANA       16'h1FF2
`endif

/* common/opm_pkg.sv */
// types for the oscillator select and low-power mode controller
// assumes the constants header is included by users
package opm_pkg;
    typedef enum logic [4:0] {
        OPM_POR   = 5'b00001,   // power-up delay
        OPM_RUN   = 5'b00010,   // executing
        OPM_STOP  = 5'b00100,   // oscillators off
        OPM_WAIT  = 5'b01000,   // bus clock gated (wait or halt)
        OPM_RECOV = 5'b10000    // recovery count before resume
    } opm_state_t;
    typedef struct packed {
        logic core;   // core timer overflow or periodic
        logic ptmr;   // capture, compare or overflow
        logic ser;    // serial 8-bit transfer done
        logic ana;    // analog comparison
    } opm_wake_t;
    typedef struct packed {
        logic int_osc_en;  // internal low-power oscillator enable
        logic ext_osc_en;  // external pin oscillator enable
        logic ext_src;     // device clock taken from external
    } opm_osc_t;
endpackage

/* verif/opm_partner.sv */
// wake-source model: external pin, port pins, reset pin and peripheral requests
// assumes one clk domain; the bench picks a source and fires it for one cycle
`timescale 1ns/1ps
module opm_partner
    import opm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       fire,
    input  wire logic [2:0] src,
    input  wire logic       vector_valid,
    output logic            ext_irq_pin_n,
    output logic      [3:0] port_a_wake_pins,
    output logic            reset_pin_n,
    output logic            watchdog_timeout,
    output opm_wake_t       periph_irq
);
    logic [1:0] hold_r;  // cycles left on a pin pulse

    // pins pulse for three cycles; peripheral levels stay until serviced
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ext_irq_pin_n    <= 1'b1;
            port_a_wake_pins <= 4'h0;
            reset_pin_n      <= 1'b1;
            watchdog_timeout <= 1'b0;
            periph_irq       <= '0;
            hold_r           <= 2'h0;
        end
        else
        begin
            watchdog_timeout <= fire && (src == 3'h6);  // one-cycle timeout
            if (vector_valid)
                periph_irq <= '0;  // all levels drop once any vector is fetched
            if (hold_r == 2'h1)
            begin
                // pins return to idle: pin high, port pulled down
                ext_irq_pin_n    <= 1'b1;
                port_a_wake_pins <= 4'h0;
                reset_pin_n      <= 1'b1;
            end
            if (hold_r != 2'h0)
                hold_r <= hold_r - 2'h1;
            if (fire)
            begin
                hold_r <= 2'h3;
                case (src)
                    3'h0: ext_irq_pin_n <= 1'b0;     // falling edge
                    3'h1: port_a_wake_pins <= 4'h8;  // rising edge on pin 3
                    3'h2: periph_irq.core <= 1'b1;
                    3'h3: periph_irq.ptmr <= 1'b1;
                    3'h4: periph_irq.ser <= 1'b1;
                    3'h5: periph_irq.ana <= 1'b1;
                    3'h7: reset_pin_n <= 1'b0;
                    default: ;
                endcase
            end
        end
    end
endmodule // opm_partner

/* verif/osc_select_low_power_modes_bench.sv */
// self-checking bench for the oscillator select and low-power sequencer
// assumes opm_ctrl and opm_partner compiled first; apb master on clk
`timescale 1ns/1ps
`include "opm_consts.svh"
module osc_select_low_power_modes_bench
    import opm_pkg::*;
;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, e, stop_req = 0, wait_req = 0, fire = 0;
    logic port_int_option = 1, halt_option = 0, long_delay_option = 0;
    logic [2:0] src = 3'h0;
    logic ext_irq_pin_n, reset_pin_n, watchdog_timeout;
    logic [3:0] port_a_wake_pins;
    opm_wake_t periph_irq;
    opm_osc_t osc_ctrl;
    logic osc_run, periph_clk_en, watchdog_clk_en, bus_clk_en, cpu_reset;
    logic irq_mask_clear, core_timer_clear, prog_timer_clear, vector_valid;
    logic [15:0] vector_addr, last_vec = 16'h0;
    int num_errors = 0, cmp_count = 0, vec_cnt = 0, mask_cnt = 0, core_cnt = 0, ptmr_cnt = 0;
    int n, m, k;
    logic [1:0] codes [4] = '{2'h2, 2'h0, 2'h3, 2'h1};  // 11 ahead of 01
    logic [2:0] srcs [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [15:0] vecs [7] = '{16'h1FFA, 16'h1FF8, 16'h1FF6, 16'h1FF4, 16'h1FF2, 16'h1FFE, 16'h1FFE};

    opm_ctrl u_opm_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_req(stop_req), .wait_req(wait_req), .ext_irq_pin_n(ext_irq_pin_n),
        .port_a_wake_pins(port_a_wake_pins), .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout),
        .periph_irq(periph_irq), .port_int_option(port_int_option), .halt_option(halt_option),
        .long_delay_option(long_delay_option), .osc_ctrl(osc_ctrl), .osc_run(osc_run),
        .periph_clk_en(periph_clk_en), .watchdog_clk_en(watchdog_clk_en), .bus_clk_en(bus_clk_en),
        .cpu_reset(cpu_reset), .irq_mask_clear(irq_mask_clear), .core_timer_clear(core_timer_clear),
        .prog_timer_clear(prog_timer_clear), .vector_valid(vector_valid), .vector_addr(vector_addr));

    opm_partner u_opm_partner (.clk(clk), .rst_n(rst_n), .fire(fire), .src(src), .vector_valid(vector_valid),
        .ext_irq_pin_n(ext_irq_pin_n), .port_a_wake_pins(port_a_wake_pins), .reset_pin_n(reset_pin_n),
        .watchdog_timeout(watchdog_timeout), .periph_irq(periph_irq));

    // 100 MHz clock
    always #5 clk = ~clk;

    // one-cycle pulses are caught here and counted, so no check can miss them
    always @(posedge clk)
    begin
        if (vector_valid === 1'b1)
        begin
            last_vec <= vector_addr;
            vec_cnt  <= vec_cnt + 1;
        end
        if (irq_mask_clear === 1'b1) mask_cnt <= mask_cnt + 1;
        if (core_timer_clear === 1'b1) core_cnt <= core_cnt + 1;
        if (prog_timer_clear === 1'b1) ptmr_cnt <= ptmr_cnt + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // apb transfer: setup, access held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int i;
        // start just after a rising edge; pready, prdata and the write all meet one edge
        @(posedge clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
            if (i > 50) begin num_errors++; conclude(); end
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // bus cycles until the bus clock comes back, bounded
    task automatic wait_bus(output int cnt);
        cnt = 0;
        while (bus_clk_en !== 1'b1)
        begin
            @(negedge clk);
            cnt++;
            if (cnt > 6000) begin num_errors++; conclude(); end
        end
    endtask

    task automatic wake(input logic [2:0] s);
        @(posedge clk);
        src <= s; fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask

    // one-cycle stop or wait instruction from the core
    task automatic enter(input logic is_stop);
        @(posedge clk);
        stop_req <= is_stop; wait_req <= !is_stop;
        @(posedge clk);
        stop_req <= 1'b0; wait_req <= 1'b0;
        repeat (3) @(negedge clk);
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        check(osc_ctrl, 3'b100);
        rst_n <= 1'b1;
        n = 0;
        @(negedge clk);
        while (cpu_reset !== 1'b0 && n < 6000) begin @(negedge clk); n++; end
        check(n >= 16 && n <= 20, 1);
        wait_bus(n);
        apb(0, `OPM_CTRL_OFF, 0, d, e); check(d, 32'h82);
        apb(0, `OPM_STAT_OFF, 0, d, e); check(d, 32'h02);
        apb(0, 12'h008, 0, d, e); check(d, 32'h0);
        check(e, 1'b1);
        // every select code; both on before switching to external
        for (k = 0; k < 4; k++)
        begin
            apb(1, `OPM_CTRL_OFF, {24'h0, 6'h20, codes[k]}, d, e);
            repeat (2) @(negedge clk);
            check(osc_ctrl, {codes[k] != 2'h1, codes[k][0], codes[k] == 2'h1});
        end
        apb(1, `OPM_CTRL_OFF, 32'h83, d, e);
        wake(3'h0); repeat (6) @(negedge clk);
        apb(0, `OPM_CTRL_OFF, 0, d, e); check(d, 32'h8B);
        apb(1, `OPM_CTRL_OFF, 32'h23, d, e);
        apb(0, `OPM_CTRL_OFF, 0, d, e); check(d, 32'h03);
        // stop, woken from port pin 3
        enter(1);
        check({osc_run, periph_clk_en, watchdog_clk_en, bus_clk_en}, 4'h0);
        check(mask_cnt, 1);
        check(core_cnt, 1);
        check(ptmr_cnt, 1);
        apb(0, `OPM_CTRL_OFF, 0, d, e); check(d, 32'h83);
        apb(0, `OPM_STAT_OFF, 0, d, e); check(d, 32'h04);
        wake(3'h1); wait_bus(n);
        check(n >= 16 && n <= 24, 1);
        check({last_vec, osc_run}, {16'h1FFA, 1'b1});
        // long delay; port pin ignored with the option off
        @(posedge clk);
        long_delay_option <= 1'b1; port_int_option <= 1'b0;
        enter(1);
        wake(3'h1); repeat (30) @(negedge clk);
        check(bus_clk_en, 1'b0);
        wake(3'h0); wait_bus(n);
        check(n >= 4064 && n <= 4072, 1);
        @(posedge clk);
        long_delay_option <= 1'b0; port_int_option <= 1'b1;
        // wait mode woken by each source except the port pins
        for (k = 0; k < 7; k++)
        begin
            m = mask_cnt;
            n = core_cnt;
            enter(0);
            check({bus_clk_en, periph_clk_en, osc_run}, 3'b011);
            check(mask_cnt - m, 1);
            check(core_cnt - n, 0);
            m = vec_cnt;
            wake(srcs[k]); wait_bus(n);
            check(vec_cnt - m, 1);
            if (k < 5) check(n <= 6, 1);
            check(last_vec, vecs[k]);
        end
        // halt: stop with the option set keeps oscillators and watchdog
        @(posedge clk);
        halt_option <= 1'b1;
        enter(1);
        check({watchdog_clk_en, osc_run, bus_clk_en}, 3'b110);
        wake(3'h0); wait_bus(n);
        check({n >= 1 && n <= 24, last_vec}, {1'b1, 16'h1FFA});
        conclude();
    end
endmodule // osc_select_low_power_modes_bench
